// ===== stack_cpu_serial_debug_port.sv
// Serial register access port, memories and pin ports of the stack processor
`timescale 1ns/1ps
`include "serial_debug_defines.svh"

// Contract
// - Load writes shift value into selected register
// - Dump copies register; MSB out two cycles later
// - Next lower bit appears every following cycle
// - Load completes in one held cycle
// - Select codes: counter, pointer, execute, stack
// - Execute runs opcode once; counter kept unless jump
// - Stack write pushes; read returns top
// - Disabled low output pins show debug signals
// - 0x36 reads pins, write toggles outputs
// - 0x37 sets bidirectional pin direction
// - 0x38 sets bidirectional output values
// - 0x39 write toggles outputs, reads zero
// - 0x3a enables output-only port bits
// - 0x3b sets output-only port values
// - Reset spares program bytes 0-3, 128-131
// - Reset: program 0xff, others zero
// - Memories: 256 program, 32 stack, 32 data
module stack_cpu_serial_debug_port #(
    parameter int STACK_DEPTH = `STACK_DEPTH,
    parameter int DATA_DEPTH = `DATA_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host serial access
    input serial_debug_pkg::host_access_t host,
    output logic shift_out,
    // Core status for the debug mux
    input serial_debug_pkg::core_status_t status,
    // Output-only port pins
    output logic [7:0] out_pins,
    // Bidirectional port pins
    input wire logic [7:0] bidir_in,
    output logic [7:0] bidir_out,
    output logic [7:0] bidir_oe
);
    localparam int SW = $clog2(STACK_DEPTH);
    localparam int DW = $clog2(DATA_DEPTH);

    // Elaboration-time refusal of depths the index logic cannot serve
    if (STACK_DEPTH < 2 || STACK_DEPTH > 256 || (1 << SW) != STACK_DEPTH) begin : g_bad_stack
        $error("STACK_DEPTH must be a power of two from 2 to 256");
    end
    if (DATA_DEPTH < 2 || DATA_DEPTH > 32 || (1 << DW) != DATA_DEPTH) begin : g_bad_data
        $error("DATA_DEPTH must be a power of two from 2 to 32");
    end

    logic [7:0] prog_mem [`PROG_DEPTH];
    logic [7:0] stack_mem [STACK_DEPTH];
    logic [7:0] data_mem [DATA_DEPTH];

    logic [7:0] shift_reg, shift_next;
    logic shift_out_reg;
    logic [7:0] pc_reg, pc_next;
    logic [7:0] sp_reg, sp_next;
    logic [7:0] bdir_reg, bdir_next;
    logic [7:0] bout_reg, bout_next;
    logic [7:0] oen_reg, oen_next;
    logic [7:0] oval_reg, oval_next;

    logic prog_we, stack_we, data_we;
    logic [7:0] prog_wa, prog_wd, stack_wd, data_wa, data_wd;
    logic [SW-1:0] stack_wa;
    logic [7:0] top, second, op;

    function automatic logic [SW-1:0] sidx(input logic [7:0] p);
        return p[SW-1:0];
    endfunction

    function automatic logic in_data(input logic [7:0] a);
        return a < 8'(DATA_DEPTH);
    endfunction

    function automatic logic [7:0] data_read(input logic [7:0] a);
        logic [7:0] r;
        r = `READ_ZERO;
        if (in_data(a)) begin
            r = data_mem[a[DW-1:0]];
        end else begin
            unique case (a)
                `ADDR_BIDIR_TOGGLE: r = bidir_in;
                `ADDR_BIDIR_DIR: r = bdir_reg;
                `ADDR_BIDIR_OUT: r = bout_reg;
                `ADDR_OUT_ENABLE: r = oen_reg;
                `ADDR_OUT_VALUE: r = oval_reg;
                default: r = `READ_ZERO;
            endcase
        end
        return r;
    endfunction

    assign top = stack_mem[sidx(sp_reg - 8'h01)];
    assign second = stack_mem[sidx(sp_reg - 8'h02)];
    assign op = shift_reg;

    always_comb begin
        shift_next = shift_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        bdir_next = bdir_reg;
        bout_next = bout_reg;
        oen_next = oen_reg;
        oval_next = oval_reg;
        prog_we = 1'b0;
        prog_wa = top;
        prog_wd = second;
        stack_we = 1'b0;
        stack_wa = sidx(sp_reg);
        stack_wd = shift_reg;
        data_we = 1'b0;
        data_wa = top;
        data_wd = second;
        if (host.load) begin
            unique case (host.sel)
                serial_debug_pkg::SEL_PROGRAM_COUNTER: pc_next = shift_reg;
                serial_debug_pkg::SEL_STACK_POINTER: sp_next = shift_reg;
                serial_debug_pkg::SEL_STACK_ACCESS: begin
                    stack_we = 1'b1;
                    sp_next = sp_reg + 8'h01;
                end
                serial_debug_pkg::SEL_EXECUTE_IN_PLACE: begin
                    // one opcode, counter untouched unless jump
                    unique case (op)
                        `OP_STORE_PROG: begin
                            prog_we = 1'b1;
                            sp_next = sp_reg - 8'h02;
                        end
                        `OP_READ_PROG: begin
                            stack_we = 1'b1;
                            stack_wa = sidx(sp_reg - 8'h01);
                            stack_wd = prog_mem[top];
                        end
                        `OP_JUMP: begin
                            pc_next = top;
                            sp_next = sp_reg - 8'h01;
                        end
                        `OP_WRITE_DATA: begin
                            data_we = 1'b1;
                            sp_next = sp_reg - 8'h02;
                        end
                        `OP_READ_DATA: begin
                            stack_we = 1'b1;
                            stack_wa = sidx(sp_reg - 8'h01);
                            stack_wd = data_read(top);
                        end
                        default: begin
                            stack_we = 1'b1;
                            sp_next = sp_reg + 8'h01;
                        end
                    endcase
                end
            endcase
        end else if (host.dump) begin
            unique case (host.sel)
                serial_debug_pkg::SEL_PROGRAM_COUNTER: shift_next = pc_reg;
                serial_debug_pkg::SEL_STACK_POINTER: shift_next = sp_reg;
                serial_debug_pkg::SEL_STACK_ACCESS: shift_next = top;
                serial_debug_pkg::SEL_EXECUTE_IN_PLACE: shift_next = `READ_ZERO;
            endcase
        end else begin
            shift_next = {shift_reg[6:0], host.shift_in};
        end
        if (data_we && !in_data(data_wa)) begin
            unique case (data_wa)
                `ADDR_BIDIR_TOGGLE: bout_next = bout_reg ^ data_wd;
                `ADDR_BIDIR_DIR: bdir_next = data_wd;
                `ADDR_BIDIR_OUT: bout_next = data_wd;
                `ADDR_OUT_TOGGLE: oval_next = oval_reg ^ data_wd;
                `ADDR_OUT_ENABLE: oen_next = data_wd;
                `ADDR_OUT_VALUE: oval_next = data_wd;
                default: oval_next = oval_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_reg <= `MEM_CLEAR;
            shift_out_reg <= 1'b0;
            pc_reg <= `MEM_CLEAR;
            sp_reg <= `MEM_CLEAR;
            bdir_reg <= `PORT_RESET;
            bout_reg <= `PORT_RESET;
            oen_reg <= `PORT_RESET;
            oval_reg <= `PORT_RESET;
        end else begin
            shift_reg <= shift_next;
            shift_out_reg <= shift_reg[7];
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            bdir_reg <= bdir_next;
            bout_reg <= bout_next;
            oen_reg <= oen_next;
            oval_reg <= oval_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `PROG_DEPTH; i++) begin
                // first four words of each bank keep contents
                if (8'(i) - `STUCK_LOW_BASE >= `STUCK_SPAN &&
                    8'(i) - `STUCK_HIGH_BASE >= `STUCK_SPAN) begin
                    prog_mem[i] <= `PROG_ERASED;
                end
            end
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= `MEM_CLEAR;
            end
            for (int i = 0; i < DATA_DEPTH; i++) begin
                data_mem[i] <= `MEM_CLEAR;
            end
        end else begin
            if (prog_we) begin
                prog_mem[prog_wa] <= prog_wd;
            end
            if (stack_we) begin
                stack_mem[stack_wa] <= stack_wd;
            end
            if (data_we && in_data(data_wa)) begin
                data_mem[data_wa[DW-1:0]] <= data_wd;
            end
        end
    end

    assign shift_out = shift_out_reg;
    assign bidir_out = bout_reg;
    assign bidir_oe = bdir_reg;

    // debug mux on low output pins
    always_comb begin
        logic [`DBG_PINS-1:0] dbg;
        dbg = {shift_out_reg, status.wait_delay, status.stop, status.sleep};
        for (int n = 0; n < 8; n++) begin
            if (oen_reg[n]) begin
                out_pins[n] = oval_reg[n];
            end else if (n < `DBG_PINS) begin
                out_pins[n] = dbg[n];
            end else begin
                out_pins[n] = 1'b0;
            end
        end
    end

    a_load_counter: assert property (@(posedge clk) disable iff (rst)
        host.load && host.sel == serial_debug_pkg::SEL_PROGRAM_COUNTER
        |=> pc_reg == $past(shift_reg))
        else $error("counter not loaded from shift register");

    a_dump_msb_delay: assert property (@(posedge clk) disable iff (rst)
        host.dump && !host.load && host.sel == serial_debug_pkg::SEL_STACK_POINTER
        |-> ##2 shift_out == $past(sp_reg[7], 2))
        else $error("dumped MSB not on serial output after two cycles");

    a_next_bit_out: assert property (@(posedge clk) disable iff (rst)
        !host.load && !host.dump |=> ##1 shift_out == $past(shift_reg[6], 2))
        else $error("next lower bit missing on serial output");

    a_idle_shift: assert property (@(posedge clk) disable iff (rst)
        !host.load && !host.dump
        |=> shift_reg == {$past(shift_reg[6:0]), $past(host.shift_in)})
        else $error("shift register did not shift in serial bit");

    a_stack_push: assert property (@(posedge clk) disable iff (rst)
        host.load && host.sel == serial_debug_pkg::SEL_STACK_ACCESS
        |=> sp_reg == $past(sp_reg) + 8'h01 && top == $past(shift_reg))
        else $error("stack push failed");

    a_execute_in_place_keeps_pc: assert property (@(posedge clk) disable iff (rst)
        host.load && host.sel == serial_debug_pkg::SEL_EXECUTE_IN_PLACE
        && shift_reg != `OP_JUMP |=> $stable(pc_reg))
        else $error("execute changed counter without a jump");

    a_debug_mux: assert property (@(posedge clk) disable iff (rst)
        !oen_reg[1] |-> out_pins[1] == status.stop && out_pins[7] == (oen_reg[7] & oval_reg[7]))
        else $error("debug mux wrong on output pins");

    a_toggle_out: assert property (@(posedge clk) disable iff (rst)
        data_we && data_wa == `ADDR_OUT_TOGGLE
        |=> oval_reg == ($past(oval_reg) ^ $past(data_wd)))
        else $error("output toggle wrong");

    a_bidir_value: assert property (@(posedge clk) disable iff (rst)
        data_we && data_wa == `ADDR_BIDIR_OUT |=> bidir_out == $past(data_wd))
        else $error("bidirectional output value not set");

    a_reset_stuck: assert property (@(posedge clk)
        rst |=> $stable(prog_mem[1]) && prog_mem[4] == `PROG_ERASED)
        else $error("program memory reset pattern wrong");

endmodule

// ===== serial_debug_defines.svh
// Depths, offsets, reset values and opcodes of the debug port block
`ifndef SERIAL_DEBUG_DEFINES_SVH
`define SERIAL_DEBUG_DEFINES_SVH

`define PROG_DEPTH 256
`define STACK_DEPTH 32
`define DATA_DEPTH 32
`define WORD_W 8

`define PROG_ERASED 8'hff
`define MEM_CLEAR 8'h00
`define PORT_RESET 8'h00
`define READ_ZERO 8'h00

// Program memory words whose reset clear is lost
`define STUCK_LOW_BASE 8'h00
`define STUCK_HIGH_BASE 8'h80
`define STUCK_SPAN 8'h04

`define ADDR_BIDIR_TOGGLE 8'h36
`define ADDR_BIDIR_DIR 8'h37
`define ADDR_BIDIR_OUT 8'h38
`define ADDR_OUT_TOGGLE 8'h39
`define ADDR_OUT_ENABLE 8'h3a
`define ADDR_OUT_VALUE 8'h3b

`define OP_STORE_PROG 8'h21
`define OP_READ_PROG 8'h3f
`define OP_JUMP 8'h3d
`define OP_WRITE_DATA 8'h77
`define OP_READ_DATA 8'h72

`define DBG_PINS 4

`endif

// ===== serial_debug_pkg.sv
// Types shared by the debug port block
package serial_debug_pkg;

    typedef enum logic [1:0] {
        SEL_PROGRAM_COUNTER = 2'h0,
        SEL_STACK_POINTER = 2'h1,
        SEL_EXECUTE_IN_PLACE = 2'h2,
        SEL_STACK_ACCESS = 2'h3
    } reg_select_t;

    typedef struct packed {
        reg_select_t sel;
        logic load;
        logic dump;
        logic shift_in;
    } host_access_t;

    typedef struct packed {
        logic sleep;
        logic stop;
        logic wait_delay;
    } core_status_t;

endpackage

// ===== serial_host_model.sv
// Behavioural host driving the serial register access pins
`timescale 1ns/1ps
`include "serial_debug_defines.svh"
module serial_host_model (
    // Clock
    input wire logic clk,
    // Serial access pins
    output serial_debug_pkg::host_access_t host,
    input wire logic shift_out
);
    initial begin
        host = '0;
    end

    // MSB first, then load held one cycle
    task automatic write_reg(input serial_debug_pkg::reg_select_t sel, input logic [7:0] value);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            host.shift_in = value[i];
        end
        @(negedge clk);
        host.sel = sel;
        host.load = 1'b1;
        @(negedge clk);
        host.load = 1'b0;
        host.shift_in = ~value[0];
    endtask

    // sample one bit per cycle, first bit two cycles after dump
    task automatic read_reg(input serial_debug_pkg::reg_select_t sel, output logic [7:0] value);
        @(negedge clk);
        host.sel = sel;
        host.dump = 1'b1;
        @(negedge clk);
        host.dump = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            value[i] = shift_out;
        end
    endtask

    task automatic push(input logic [7:0] value);
        write_reg(serial_debug_pkg::SEL_STACK_ACCESS, value);
    endtask

    task automatic execute_in_place(input logic [7:0] op);
        write_reg(serial_debug_pkg::SEL_EXECUTE_IN_PLACE, op);
    endtask

    // byte, then address, then store opcode
    task automatic prog_store(input logic [7:0] addr, input logic [7:0] value);
        push(value);
        push(addr);
        execute_in_place(`OP_STORE_PROG);
    endtask

    // only defined data addresses are used
    task automatic data_write(input logic [7:0] addr, input logic [7:0] value);
        push(value);
        push(addr);
        execute_in_place(`OP_WRITE_DATA);
    endtask

    // Push an address, run a read opcode, return the new top
    task automatic fetch(input logic [7:0] op, input logic [7:0] addr, output logic [7:0] value);
        push(addr);
        execute_in_place(op);
        read_reg(serial_debug_pkg::SEL_STACK_ACCESS, value);
    endtask
endmodule

// ===== tb_top.sv
// Testbench for the serial debug port: register access, pin ports, reset
`timescale 1ns/1ps
`include "serial_debug_defines.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    serial_debug_pkg::host_access_t host_bus;
    serial_debug_pkg::core_status_t status = 3'b101;
    logic shift_out;
    logic [7:0] out_pins;
    logic [7:0] bidir_out;
    logic [7:0] bidir_oe;
    logic [7:0] ext_level = 8'h3c;
    logic [7:0] bidir_in;
    logic [7:0] rd;
    int n_fail = 0;
    int n_checks = 0;

    always #12.5 clk = ~clk;

    // Driven bits follow the port, the rest the outside world
    assign bidir_in = (bidir_out & bidir_oe) | (ext_level & ~bidir_oe);

    stack_cpu_serial_debug_port dut (
        .clk(clk),
        .rst(rst),
        .host(host_bus),
        .shift_out(shift_out),
        .status(status),
        .out_pins(out_pins),
        .bidir_in(bidir_in),
        .bidir_out(bidir_out),
        .bidir_oe(bidir_oe)
    );

    serial_host_model host_ctl (
        .clk(clk),
        .host(host_bus),
        .shift_out(shift_out)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results;
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        results();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        host_ctl.read_reg(serial_debug_pkg::SEL_PROGRAM_COUNTER, rd);
        check(rd, 8'h00, "counter after reset");
        host_ctl.read_reg(serial_debug_pkg::SEL_STACK_POINTER, rd);
        check(rd, 8'h00, "pointer after reset");
        check(out_pins, {4'h0, 1'b0, 3'b101}, "debug mux");
        status = 3'b110;
        @(negedge clk);
        check(out_pins, {4'h0, 1'b0, 3'b011}, "debug mux order");
        $display("test reset and mux done");

        host_ctl.write_reg(serial_debug_pkg::SEL_PROGRAM_COUNTER, 8'ha5);
        host_ctl.read_reg(serial_debug_pkg::SEL_PROGRAM_COUNTER, rd);
        check(rd, 8'ha5, "counter write");
        host_ctl.push(8'h3c);
        host_ctl.push(8'hc3);
        host_ctl.read_reg(serial_debug_pkg::SEL_STACK_ACCESS, rd);
        check(rd, 8'hc3, "stack top");
        host_ctl.read_reg(serial_debug_pkg::SEL_STACK_POINTER, rd);
        check(rd, 8'h02, "pointer after pushes");
        host_ctl.read_reg(serial_debug_pkg::SEL_EXECUTE_IN_PLACE, rd);
        check(rd, 8'h00, "execute reads zero");
        $display("test register access done");

        host_ctl.data_write(`ADDR_OUT_ENABLE, 8'hff);
        host_ctl.data_write(`ADDR_OUT_VALUE, 8'h5a);
        check(out_pins, 8'h5a, "out value");
        host_ctl.data_write(`ADDR_OUT_TOGGLE, 8'h0f);
        check(out_pins, 8'h55, "out toggle");
        host_ctl.fetch(`OP_READ_DATA, `ADDR_OUT_TOGGLE, rd);
        check(rd, 8'h00, "toggle reads zero");
        host_ctl.data_write(`ADDR_OUT_ENABLE, 8'h0f);
        check(out_pins, {4'h0, 4'h5}, "partial enable");
        host_ctl.data_write(`ADDR_BIDIR_DIR, 8'hf0);
        host_ctl.data_write(`ADDR_BIDIR_OUT, 8'ha5);
        check(bidir_oe, 8'hf0, "direction");
        check(bidir_out, 8'ha5, "bidir out");
        host_ctl.data_write(`ADDR_BIDIR_TOGGLE, 8'h04);
        check(bidir_out, 8'ha1, "bidir toggle");
        host_ctl.fetch(`OP_READ_DATA, `ADDR_BIDIR_TOGGLE, rd);
        check(rd, 8'hac, "pin levels");
        host_ctl.read_reg(serial_debug_pkg::SEL_PROGRAM_COUNTER, rd);
        check(rd, 8'ha5, "counter kept");
        $display("test ports done");

        host_ctl.prog_store(8'h10, 8'h42);
        host_ctl.fetch(`OP_READ_PROG, 8'h10, rd);
        check(rd, 8'h42, "program store");
        host_ctl.fetch(`OP_READ_PROG, 8'hff, rd);
        check(rd, `PROG_ERASED, "top byte erased");
        host_ctl.push(8'h80);
        host_ctl.execute_in_place(`OP_JUMP);
        host_ctl.read_reg(serial_debug_pkg::SEL_PROGRAM_COUNTER, rd);
        check(rd, 8'h80, "jump");
        host_ctl.execute_in_place(8'h05);
        host_ctl.read_reg(serial_debug_pkg::SEL_STACK_ACCESS, rd);
        check(rd, 8'h05, "execute_in_place plain byte pushes");
        $display("test program done");

        host_ctl.prog_store(8'h02, 8'h11);
        host_ctl.prog_store(8'h83, 8'h22);
        host_ctl.prog_store(8'h04, 8'h33);
        host_ctl.prog_store(8'h7f, 8'h44);
        @(negedge clk);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        host_ctl.fetch(`OP_READ_PROG, 8'h02, rd);
        check(rd, 8'h11, "low spared byte");
        host_ctl.fetch(`OP_READ_PROG, 8'h83, rd);
        check(rd, 8'h22, "high spared byte");
        host_ctl.fetch(`OP_READ_PROG, 8'h04, rd);
        check(rd, 8'hff, "cleared byte");
        host_ctl.fetch(`OP_READ_PROG, 8'h7f, rd);
        check(rd, 8'hff, "cleared byte");
        host_ctl.fetch(`OP_READ_DATA, 8'h1f, rd);
        check(rd, 8'h00, "data cleared");
        $display("test reset defect done");
        results();
    end
endmodule
